// >>> src/hivd_params.svh
// constants for the hardware interrupt vector dispatch block
`ifndef HIVD_PARAMS_SVH
`define HIVD_PARAMS_SVH
`define HIVD_NUM_VEC 48
`define HIVD_VEC_FIRST 16'h0000
`define HIVD_VEC_LAST 16'h005e
`define HIVD_EN_ADDR 16'hc00e
`define HIVD_EN_RST 16'h0000
`define HIVD_HW_MASK 48'hffff_3737_fdff
`define HIVD_SECOND_TIMER_EN_BIT 1
`endif

// >>> src/hivd_pkg.sv
// types shared by the interrupt vector dispatch block
package hivd_pkg;
  // events of one usb engine, one-cycle pulses
  typedef struct packed {
    logic [7:0] ep_done;
    logic per_sof;
    logic per_reset;
    logic host_ins_rem;
    logic host_sof;
    logic host_done;
  } hivd_usb_src_t;

  // every peripheral event that can raise a hardware interrupt
  typedef struct packed {
    hivd_usb_src_t usb_engine_two;
    hivd_usb_src_t usb_engine_one;
    logic otg_change;
    logic spi_dma_done;
    logic spi_rx;
    logic spi_tx;
    logic mbox_tx_full;
    logic mbox_rx_empty;
    logic ide_dma_done;
    logic hss_rx_full;
    logic hss_dma_done;
    logic uart_rx;
    logic uart_tx;
    logic general_pin_irq_b;
    logic general_pin_irq_a;
    logic second_timer;
    logic first_timer;
  } hivd_src_t;
endpackage

// >>> src/hivd_dispatch.sv
// interrupt vector table, enable register and lowest-first dispatcher
`timescale 1ns/1ps
`include "hivd_params.svh"

// Notes on behaviour
// - exactly 48 interrupt numbers, each with its own vector slot
// - vector of number n is the 16-bit word at byte address 2n
// - hardware dispatch and software call of n reach the same vector
// - numbers without hardware source work only as software interrupts
// - vector slots are plain read/write memory; writes redirect later dispatch
// - numbers 0,1 are the timers; 2,3 the general pin lines
// - number 4 is uart transmit, 5 is uart receive
// - number 6 is serial dma done, 7 is serial receiver full
// - number 8 is ide dma done, 15 is otg id or vbus change
// - number 10 is mailbox receive empty, 11 mailbox transmit full
// - numbers 12,13,14 are spi transmit, receive and dma done
// - engine one host and peripheral events on 16,17,18,20,21
// - engine two host and peripheral events on 24,25,26,28,29
// - engine one endpoints 0 to 7 on numbers 32 to 39
// - engine two endpoints 0 to 7 on numbers 40 to 47
// - numbers 9,19,22,23,27,30,31 have no hardware source
// - enable register at 0xc00e gates sources; value 2 enables second_timer
module hivd_dispatch #(
  parameter int NUM_VEC = `HIVD_NUM_VEC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_wdata_i,
  output logic [15:0] mem_rdata_o,
  output logic mem_hit_o,
  input wire hivd_pkg::hivd_src_t src_i,
  output logic irq_req_o,
  output logic [5:0] irq_num_o,
  output logic [15:0] irq_vec_o,
  input wire logic irq_ack_i,
  input wire logic sw_req_i,
  input wire logic [5:0] sw_num_i,
  output logic sw_valid_o,
  output logic [15:0] sw_vec_o,
  output logic [47:0] pending_o
);

  // the table layout and address decode serve exactly 48 slots
  if (NUM_VEC != 48) begin : g_bad_num
    $error("hivd_dispatch serves exactly 48 vectors");
  end

  logic [15:0] vec_mem [NUM_VEC];
  logic [15:0] en_q;
  logic [47:0] pend_q;
  logic [47:0] pend_d;
  logic valid_q;
  logic [5:0] num_q;
  logic [15:0] vec_q;
  logic [15:0] rdata_q;
  logic hit_q;
  logic sw_valid_q;
  logic [15:0] sw_vec_q;

  // byte address 2n selects slot n
  wire vec_hit = (mem_addr_i <= `HIVD_VEC_LAST) && !mem_addr_i[0];
  wire [5:0] vec_idx = mem_addr_i[6:1];
  wire en_hit = (mem_addr_i == `HIVD_EN_ADDR);
  wire vec_wr = mem_wr_i && vec_hit;
  wire en_wr = mem_wr_i && en_hit;

  // event vector ordered by interrupt number
  hivd_pkg::hivd_usb_src_t u1;
  hivd_pkg::hivd_usb_src_t u2;
  assign u1 = src_i.usb_engine_one;
  assign u2 = src_i.usb_engine_two;
  wire [47:0] evt_raw;
  assign evt_raw[47:32] = {u2.ep_done, u1.ep_done};
  assign evt_raw[31:16] = {2'b00, u2.per_sof, u2.per_reset, 1'b0,
                           u2.host_ins_rem, u2.host_sof, u2.host_done,
                           2'b00, u1.per_sof, u1.per_reset, 1'b0,
                           u1.host_ins_rem, u1.host_sof, u1.host_done};
  assign evt_raw[15:0] = {src_i.otg_change, src_i.spi_dma_done,
                          src_i.spi_rx, src_i.spi_tx, src_i.mbox_tx_full,
                          src_i.mbox_rx_empty, 1'b0, src_i.ide_dma_done,
                          src_i.hss_rx_full, src_i.hss_dma_done,
                          src_i.uart_rx, src_i.uart_tx,
                          src_i.general_pin_irq_b, src_i.general_pin_irq_a,
                          src_i.second_timer, src_i.first_timer};

  // enable bit k gates numbers k, k+16 and k+32
  wire [47:0] en48 = {en_q, en_q, en_q};
  wire [47:0] evt_hw = evt_raw & `HIVD_HW_MASK & en48;
  wire [47:0] req = pend_q & en48;
  wire any_req = |req;

  function automatic logic [5:0] lowest(input logic [47:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 47; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction
  wire [5:0] pick = lowest(req);

  // a write to the slot being captured is forwarded
  wire fwd = vec_wr && (vec_idx == pick);
  wire [15:0] pick_vec = fwd ? mem_wdata_i : vec_mem[pick];
  wire take = !valid_q && any_req;
  wire acked = valid_q && irq_ack_i;
  wire [47:0] clr = acked ? (48'h0000_0000_0001 << num_q) : 48'h0;

  // clear on acceptance, a new event in the same cycle wins
  assign pend_d = (pend_q & ~clr) | evt_hw;

  // vector table storage, ordinary memory with no reset
  always_ff @(posedge core_clk_i) begin
    if (vec_wr) begin
      vec_mem[vec_idx] <= mem_wdata_i;
    end
  end

  // enable register and pending latches
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      en_q <= `HIVD_EN_RST;
      pend_q <= 48'h0;
    end else begin
      pend_q <= pend_d;
      if (en_wr) begin
        en_q <= mem_wdata_i;
      end
    end
  end

  // dispatch presentation, held until the core acknowledges
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      num_q <= 6'h00;
      vec_q <= 16'h0000;
    end else if (acked) begin
      valid_q <= 1'b0;
    end else if (take) begin
      // present lowest number with its vector
      valid_q <= 1'b1;
      num_q <= pick;
      vec_q <= pick_vec;
    end else if (valid_q && vec_wr && vec_idx == num_q) begin
      // rewrite while waiting redirects this dispatch
      vec_q <= mem_wdata_i;
    end
  end

  // software call looks up the same table
  wire sw_fwd = vec_wr && (vec_idx == sw_num_i);
  wire sw_ok = sw_num_i < 6'(NUM_VEC);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sw_valid_q <= 1'b0;
      sw_vec_q <= 16'h0000;
    end else begin
      sw_valid_q <= sw_req_i && sw_ok;
      if (sw_req_i && sw_ok) begin
        sw_vec_q <= sw_fwd ? mem_wdata_i : vec_mem[sw_num_i];
      end
    end
  end

  // register read port, answer one cycle after the strobe
  wire [15:0] rd_val = vec_hit ? vec_mem[vec_idx] :
                       (en_hit ? en_q : 16'h0000);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
      hit_q <= 1'b0;
    end else begin
      hit_q <= mem_rd_i && (vec_hit || en_hit);
      if (mem_rd_i) begin
        rdata_q <= rd_val;
      end
    end
  end

  assign mem_rdata_o = rdata_q;
  assign mem_hit_o = hit_q;
  assign irq_req_o = valid_q;
  assign irq_num_o = num_q;
  assign irq_vec_o = vec_q;
  assign sw_valid_o = sw_valid_q;
  assign sw_vec_o = sw_vec_q;
  assign pending_o = pend_q;

  // helper: winner one cycle back for the ordering check
  logic [5:0] pick_past_q;
  logic [5:0] ack_num_q;
  always_ff @(posedge core_clk_i) begin
    pick_past_q <= pick;
    ack_num_q <= num_q;
  end

  // sourceless numbers never become pending
  a_reserved_quiet: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (pend_q & ~`HIVD_HW_MASK) == 48'h0)
    else $error("sourceless interrupt became pending");

  // enabled events are latched on the next edge
  a_event_latched: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (evt_hw != 48'h0) |=> ((pend_q & $past(evt_hw)) == $past(evt_hw)))
    else $error("enabled event was not latched");

  // second_timer needs enable bit 1 set, as in value 2
  a_second_timer_gate: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (src_i.second_timer && !pend_q[1] && !en_q[`HIVD_SECOND_TIMER_EN_BIT])
    |=> !pend_q[1])
    else $error("disabled second_timer event was latched");

  // enable register takes the written word
  a_enable_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    en_wr |=> (en_q == $past(mem_wdata_i)))
    else $error("enable register write lost");

  // a fresh presentation carries the lowest request
  a_lowest_first: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(valid_q) |-> (num_q == pick_past_q) && $past(any_req))
    else $error("dispatch did not pick lowest number");

  // presented request stays pending until accepted
  a_present_pending: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    valid_q |-> pend_q[num_q] && (vec_q == vec_mem[num_q]))
    else $error("presented request lost pending or vector");

  // acceptance drops the request one edge later
  a_ack_clears: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    acked |=> !valid_q && (pend_q[ack_num_q] == $past(evt_hw[num_q])))
    else $error("accepted request not cleared");

  // software call returns the slot of its number
  a_sw_vector: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (sw_req_i && sw_ok && !mem_wr_i)
    |=> sw_valid_o && (sw_vec_o == vec_mem[$past(sw_num_i)]))
    else $error("software call returned wrong vector");

  // slot readback after a write
  a_slot_readback: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (vec_wr ##1 (mem_rd_i && !mem_wr_i && mem_addr_i == $past(mem_addr_i)))
    |=> (mem_rdata_o == $past(mem_wdata_i, 2)))
    else $error("vector slot readback mismatch");

  // a call with a number past the table is refused
  a_sw_refused: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (sw_req_i && !sw_ok) |=> !sw_valid_o)
    else $error("out of range software call answered");

  // software vector holds between calls
  a_sw_hold: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !sw_req_i |=> $stable(sw_vec_o))
    else $error("software vector changed without a call");

  // a waiting presentation keeps its number
  a_req_holds: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (valid_q && !irq_ack_i) |=> valid_q && $stable(num_q))
    else $error("presentation dropped before acceptance");

  // a waiting presentation keeps its vector unless rewritten
  a_vec_holds: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (valid_q && !irq_ack_i && !vec_wr) |=> $stable(vec_q))
    else $error("presented vector changed without a write");

  // presented number lies inside the table
  a_num_range: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    valid_q |-> (num_q < 6'h30))
    else $error("presented number outside the table");

  // nothing is presented without a request
  a_idle_quiet: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (!valid_q && !any_req) |=> !valid_q)
    else $error("presentation without a pending request");

  // a disabled number never becomes newly pending
  a_gated_drop: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (pend_d & ~pend_q & ~en48) == 48'h0)
    else $error("disabled number became pending");

  // an event that meets its own acceptance stays pending
  a_set_wins: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (acked && evt_hw[num_q]) |=> pend_q[ack_num_q])
    else $error("clear won over a new event");

  // odd addresses neither hit nor return data
  a_odd_ignored: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (mem_rd_i && mem_addr_i[0]) |=> !mem_hit_o && (mem_rdata_o == 16'h0000))
    else $error("odd address answered");

  // enable register reads back its value
  a_enable_read: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (mem_rd_i && en_hit) |=> (mem_rdata_o == $past(en_q)))
    else $error("enable register readback mismatch");

  // read data holds between reads
  a_rdata_hold: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !mem_rd_i |=> $stable(mem_rdata_o))
    else $error("read data changed without a read");

  c_two_pending: cover property (
    @(posedge core_clk_i) disable iff (rst_i)
    $countones(req) > 1 && take);
  c_accept: cover property (
    @(posedge core_clk_i) disable iff (rst_i) acked);
  c_sw_call: cover property (
    @(posedge core_clk_i) disable iff (rst_i) sw_req_i && sw_num_i == 6'h09);
  c_redirect: cover property (
    @(posedge core_clk_i) disable iff (rst_i)
    valid_q && vec_wr && vec_idx == num_q);

endmodule

// >>> bench/hivd_core_model.sv
// core model that takes presented interrupts and acknowledges them
`timescale 1ns/1ps
module hivd_core_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic irq_req_i,
  input wire logic [5:0] irq_num_i,
  input wire logic [15:0] irq_vec_i,
  input wire logic [3:0] delay_i,
  output logic irq_ack_o,
  output logic [5:0] got_num_o,
  output logic [15:0] got_vec_o,
  output int got_cnt_o
);
  initial begin
    irq_ack_o = 1'b0;
    got_num_o = 6'h00;
    got_vec_o = 16'h0000;
    got_cnt_o = 0;
  end
  // wait delay_i cycles, then take number and vector with a one-cycle ack
  always begin
    @(negedge core_clk_i);
    if (!rst_i && irq_req_i === 1'b1) begin
      repeat (delay_i) @(negedge core_clk_i);
      irq_ack_o = 1'b1;
      got_num_o = irq_num_i;
      got_vec_o = irq_vec_i;
      got_cnt_o++;
      @(negedge core_clk_i);
      irq_ack_o = 1'b0;
    end
  end
endmodule

// >>> bench/hivd_dispatch_tb.sv
// self-checking bench for the interrupt vector dispatcher
`timescale 1ns/1ps
`include "hivd_params.svh"
module hivd_dispatch_tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, sw_req = 1'b0, ack;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, vec, sw_vec, g_vec;
  logic [5:0] sw_num = 6'h00, num, g_num;
  logic [40:0] src = '0;
  logic [3:0] dly = 4'h0;
  logic [47:0] pend, mask;
  logic hit, req, sw_valid;
  logic [15:0] d;
  logic h;
  int fails = 0, check_count = 0, cyc = 0, got;
  `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    fails++; $display("FAIL %s exp %h got %h", nm, e, g); end end
  always #20 core_clk_i = ~core_clk_i;
  hivd_dispatch dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .mem_addr_i(addr), .mem_wr_i(wr), .mem_rd_i(rd), .mem_wdata_i(wdata),
    .mem_rdata_o(rdata), .mem_hit_o(hit),
    .src_i(hivd_pkg::hivd_src_t'(src)), .irq_req_o(req), .irq_num_o(num),
    .irq_vec_o(vec), .irq_ack_i(ack), .sw_req_i(sw_req),
    .sw_num_i(sw_num), .sw_valid_o(sw_valid), .sw_vec_o(sw_vec),
    .pending_o(pend));
  hivd_core_model core (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .irq_req_i(req), .irq_num_i(num), .irq_vec_i(vec), .delay_i(dly),
    .irq_ack_o(ack), .got_num_o(g_num), .got_vec_o(g_vec),
    .got_cnt_o(got));
  // source bit of interrupt number n, -1 where n has no source
  function automatic int src_of(int n);
    if (n <= 8) return n;
    if (n >= 10 && n <= 18) return n - 1;
    if (n == 20 || n == 21) return n - 2;
    if (n >= 24 && n <= 26) return n + 4;
    if (n == 28 || n == 29) return n + 3;
    if (n >= 32 && n <= 39) return n - 12;
    if (n >= 40) return n - 7;
    return -1;
  endfunction
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] v);
    @(negedge core_clk_i);
    wr = w;
    rd = ~w;
    addr = a;
    wdata = v;
    @(negedge core_clk_i);
    wr = 1'b0;
    rd = 1'b0;
    d = rdata;
    h = hit;
  endtask
  task automatic pulse(input int b);
    @(negedge core_clk_i);
    src[b] = 1'b1;
    @(negedge core_clk_i);
    src = '0;
  endtask
  task automatic take(input int n, input int v = -1);
    int c;
    logic [15:0] ev;
    c = got;
    ev = (v < 0) ? 16'h1000 + n[15:0] : v[15:0];
    for (int i = 0; i < 60 && got == c; i++) @(negedge core_clk_i);
    `CHK("irq_num", n[5:0], g_num)
    `CHK("irq_vec", ev, g_vec)
  endtask
  task automatic t_regs();
    bus(1'b0, `HIVD_EN_ADDR, 16'h0000);
    `CHK("en_rst", 16'h0000, d)
    for (int n = 0; n < 48; n++) bus(1'b1, 16'(2 * n), 16'h1000 + 16'(n));
    bus(1'b0, 16'h005e, 16'h0000);
    `CHK("slot47", 16'h102f, d)
    `CHK("slot_hit", 1'b1, h)
    bus(1'b0, 16'h0003, 16'h0000);
    `CHK("odd_hit", 1'b0, h)
    bus(1'b0, 16'h0060, 16'h0000);
    `CHK("past_end", 16'h0000, d)
    bus(1'b1, `HIVD_EN_ADDR, 16'hffff);
    bus(1'b0, `HIVD_EN_ADDR, 16'h0000);
    `CHK("en_rw", 16'hffff, d)
  endtask
  task automatic t_sw();
    for (int n = 9; n < 50; n += 20) begin
      @(negedge core_clk_i);
      sw_req = 1'b1;
      sw_num = 6'(n);
      @(negedge core_clk_i);
      sw_req = 1'b0;
      `CHK("sw_valid", n < 48, sw_valid)
      if (n < 48) `CHK("sw_vec", 16'h1000 + 16'(n), sw_vec)
    end
  endtask
  task automatic t_map();
    for (int n = 0; n < 48; n++) if (src_of(n) >= 0) begin
      pulse(src_of(n));
      `CHK("pend_one", 48'h1 << n, pend)
      take(n);
    end
  endtask
  task automatic t_drain();
    dly = 4'h3;
    mask = '0;
    for (int n = 0; n < 48; n++) if (src_of(n) >= 0) mask[n] = 1'b1;
    pulse(40);
    @(negedge core_clk_i);
    src = '1;
    @(negedge core_clk_i);
    src = '0;
    `CHK("pend_all", mask, pend)
    take(47);
    for (int n = 0; n < 47; n++) if (mask[n]) take(n);
    @(negedge core_clk_i);
    `CHK("pend_empty", 48'h0, pend)
    dly = 4'h0;
  endtask
  task automatic t_gate();
    bus(1'b1, `HIVD_EN_ADDR, 16'h0002);
    bus(1'b1, 16'h0002, 16'h1001);
    pulse(0);
    pulse(src_of(16));
    `CHK("gated", 48'h0, pend)
    pulse(src_of(33));
    take(33);
    bus(1'b1, 16'h0002, 16'h1031);
    pulse(1);
    take(1, 16'h1031);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // cycle ceiling against a hang
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_regs();
    t_sw();
    t_map();
    t_drain();
    t_gate();
    complete_run();
  end
endmodule
